// [hw/pwmaq_cmp_reg.sv]
// pwmaq_cmp_reg: one compare value with shadow and active copies
`timescale 1ns/1ps
module pwmaq_cmp_reg
    import pwmaq_pkg::*;
#(
    parameter int W = DATA_W
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // software write
    input wire logic wr_en,
    input wire logic [W-1:0] wr_data,
    // mode
    input wire logic imm_mode,
    input wire logic [1:0] load_mode,
    // time base events
    input wire logic step,
    input wire logic at_zero,
    input wire logic at_prd,
    // values
    output logic [W-1:0] active_r,
    output logic [W-1:0] shadow_r
);
    logic load_w;

    // =====================================================================
    // load strobe
    always_comb begin
        case (pwmaq_ld_t'(load_mode))
            PWMAQ_LD_ZERO: load_w = at_zero;
            PWMAQ_LD_PRD: load_w = at_prd;
            PWMAQ_LD_BOTH: load_w = at_zero | at_prd;
            default: load_w = 1'b0;
        endcase
    end

    // =====================================================================
    // shadow copy
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            shadow_r <= W'(CMP_RST);
        end else if (ce && wr_en && !imm_mode) begin
            shadow_r <= wr_data;
        end
    end

    // =====================================================================
    // active copy; a write landing with a load still moves the old shadow
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            active_r <= W'(CMP_RST);
        end else if (ce) begin
            if (imm_mode && wr_en) begin
                active_r <= wr_data;
            end else if (!imm_mode && step && load_w) begin
                active_r <= shadow_r; // [RULE11]
            end
        end
    end
endmodule : pwmaq_cmp_reg

// [hw/pwmaq_pkg.sv]
// pwmaq_pkg: constants and types for the pwm action-qualifier block
package pwmaq_pkg;
    // =====================================================================
    // widths
    localparam int DATA_W = 16;
    localparam int ADR_W = 8;
    // =====================================================================
    // register byte offsets
    localparam logic [7:0] OFS_CTL_A = 8'h00;
    localparam logic [7:0] OFS_CTL_B = 8'h04;
    localparam logic [7:0] OFS_CMP_A = 8'h08;
    localparam logic [7:0] OFS_CMP_B = 8'h0c;
    localparam logic [7:0] OFS_CMPCTL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h14;
    // =====================================================================
    // action control field positions (lsb of each 2-bit field)
    localparam int F_CBD = 10;
    localparam int F_CBU = 8;
    localparam int F_CAD = 6;
    localparam int F_CAU = 4;
    localparam int F_PRD = 2;
    localparam int F_ZRO = 0;
    localparam logic [15:0] CTL_RW_MASK = 16'h0fff;
    localparam logic [15:0] CTL_RST = 16'h0000;
    // =====================================================================
    // compare control fields
    localparam int CC_LDA = 0;
    localparam int CC_LDB = 2;
    localparam int CC_IMMA = 4;
    localparam int CC_IMMB = 5;
    localparam logic [15:0] CMPCTL_MASK = 16'h003f;
    localparam logic [15:0] CMPCTL_RST = 16'h0000;
    localparam logic [15:0] CMP_RST = 16'h0000;
    // =====================================================================
    // status bits
    localparam int ST_OUT_A = 0;
    localparam int ST_OUT_B = 1;
    localparam int ST_UP = 2;
    // =====================================================================
    // types
    typedef enum logic [1:0] {
        PWMAQ_NOP = 2'b00,
        PWMAQ_CLR = 2'b01,
        PWMAQ_SET = 2'b10,
        PWMAQ_TGL = 2'b11
    } pwmaq_act_t;
    typedef enum logic [1:0] {
        PWMAQ_LD_ZERO = 2'b00,
        PWMAQ_LD_PRD = 2'b01,
        PWMAQ_LD_BOTH = 2'b10,
        PWMAQ_LD_FRZ = 2'b11
    } pwmaq_ld_t;
endpackage : pwmaq_pkg

// [hw/pwmaq_top.sv]
// pwmaq_top: action qualifier for two pwm outputs with wishbone registers
//
// Behaviour
// RULE1: output a field 11:10 acts on compare b match while counting down.
// RULE2: output a field 9:8 acts on compare b match while counting up.
// RULE3: output a field 7:6 acts on compare a match while counting down.
// RULE4: output a field 5:4 acts on compare a match while counting up.
// RULE5: output a field 3:2 acts when counter equals period.
// RULE6: output a field 1:0 acts when counter equals zero.
// RULE7: action codes: 00 hold, 01 low, 10 high, 11 invert.
// RULE8: up-down mode at period, direction counts as down.
// RULE9: up-down mode at zero, direction counts as up.
// RULE10: output b register mirrors the fields; bits 15:12 read zero.
// RULE11: compare matches use active values, loaded from shadow per load mode.
// RULE12: outputs hold between events; reset gives low outputs, no actions.
// RULE13: simultaneous events on one output apply one action by fixed priority.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module pwmaq_top
    import pwmaq_pkg::*;
#(
    parameter int W = DATA_W
) (
    // clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // time base
    input wire logic [W-1:0] time_base_counter,
    input wire logic [W-1:0] time_base_period,
    input wire logic tb_step,
    input wire logic tb_count_up,
    input wire logic tb_updown,
    // qualified outputs
    output logic pwm_output_a,
    output logic pwm_output_b
);
    logic [15:0] ctl_a_r;
    logic [15:0] ctl_b_r;
    logic [15:0] cmpctl_r;
    logic [W-1:0] compare_value_a_act;
    logic [W-1:0] compare_value_a_shd;
    logic [W-1:0] compare_value_b_act;
    logic [W-1:0] compare_value_b_shd;
    logic req_w;
    logic wr_w;
    logic at_zero_w;
    logic at_prd_w;
    logic ca_hit_w;
    logic cb_hit_w;
    logic up_w;
    logic step_w;
    pwmaq_act_t act_a_w;
    pwmaq_act_t act_b_w;
    logic [15:0] compare_value_a_src_w;
    logic [15:0] compare_value_b_src_w;
    logic [31:0] rd_nxt;

    // =====================================================================
    // helpers
    function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
        return adr[ADR_W-1:2] == ofs[ADR_W-1:2];
    endfunction : hit

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        logic [15:0] m;
        m = old;
        if (sel[0]) m[7:0] = dat[7:0];
        if (sel[1]) m[15:8] = dat[15:8];
        return m;
    endfunction : merge16

    // lowest priority first, each enabled event overrides: zero, period, cmp a, cmp b
    function automatic pwmaq_act_t sel_act(input logic [15:0] ctl,
                                           input logic cb, input logic ca,
                                           input logic pz, input logic zr,
                                           input logic up);
        logic [1:0] a;
        logic [1:0] f;
        a = 2'b00;
        if (zr) a = ctl[F_ZRO+:2]; // [RULE6]
        f = ctl[F_PRD+:2];
        if (pz && f != 2'b00) a = f; // [RULE5]
        f = up ? ctl[F_CAU+:2] : ctl[F_CAD+:2]; // [RULE3] [RULE4]
        if (ca && f != 2'b00) a = f;
        f = up ? ctl[F_CBU+:2] : ctl[F_CBD+:2]; // [RULE1] [RULE2]
        if (cb && f != 2'b00) a = f; // [RULE13]
        return pwmaq_act_t'(a);
    endfunction : sel_act

    function automatic logic apply_act(input pwmaq_act_t a, input logic cur);
        logic n;
        case (a)
            PWMAQ_CLR: n = 1'b0; // [RULE7]
            PWMAQ_SET: n = 1'b1;
            PWMAQ_TGL: n = ~cur;
            default: n = cur; // [RULE12]
        endcase
        return n;
    endfunction : apply_act

    // =====================================================================
    // bus decode; one wait state, ack cleared the cycle after it is given
    assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_w = req_w && wb_we_i;
    assign compare_value_a_src_w = 16'(cmpctl_r[CC_IMMA] ? compare_value_a_act : compare_value_a_shd);
    assign compare_value_b_src_w = 16'(cmpctl_r[CC_IMMB] ? compare_value_b_act : compare_value_b_shd);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else if (ce) begin
            wb_ack_o <= req_w;
        end
    end

    // =====================================================================
    // action control registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl_a_r <= CTL_RST; // [RULE12]
        end else if (ce && wr_w && hit(wb_adr_i, OFS_CTL_A)) begin
            ctl_a_r <= merge16(ctl_a_r, wb_dat_i, wb_sel_i) & CTL_RW_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ctl_b_r <= CTL_RST;
        end else if (ce && wr_w && hit(wb_adr_i, OFS_CTL_B)) begin
            ctl_b_r <= merge16(ctl_b_r, wb_dat_i, wb_sel_i) & CTL_RW_MASK; // [RULE10]
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cmpctl_r <= CMPCTL_RST;
        end else if (ce && wr_w && hit(wb_adr_i, OFS_CMPCTL)) begin
            cmpctl_r <= merge16(cmpctl_r, wb_dat_i, wb_sel_i) & CMPCTL_MASK;
        end
    end

    // =====================================================================
    // compare values
    pwmaq_cmp_reg #(.W(W)) u_cmp_a (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .wr_en(wr_w && hit(wb_adr_i, OFS_CMP_A)),
        .wr_data(W'(merge16(compare_value_a_src_w, wb_dat_i, wb_sel_i))),
        .imm_mode(cmpctl_r[CC_IMMA]),
        .load_mode(cmpctl_r[CC_LDA+:2]),
        .step(tb_step),
        .at_zero(at_zero_w),
        .at_prd(at_prd_w),
        .active_r(compare_value_a_act),
        .shadow_r(compare_value_a_shd)
    );

    pwmaq_cmp_reg #(.W(W)) u_cmp_b (
        .mclk(mclk),
        .rst_b(rst_b),
        .ce(ce),
        .wr_en(wr_w && hit(wb_adr_i, OFS_CMP_B)),
        .wr_data(W'(merge16(compare_value_b_src_w, wb_dat_i, wb_sel_i))),
        .imm_mode(cmpctl_r[CC_IMMB]),
        .load_mode(cmpctl_r[CC_LDB+:2]),
        .step(tb_step),
        .at_zero(at_zero_w),
        .at_prd(at_prd_w),
        .active_r(compare_value_b_act),
        .shadow_r(compare_value_b_shd)
    );

    // =====================================================================
    // read mux; unmapped addresses read zero and are still acked
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (hit(wb_adr_i, OFS_CTL_A)) rd_nxt[15:0] = ctl_a_r;
        if (hit(wb_adr_i, OFS_CTL_B)) rd_nxt[15:0] = ctl_b_r;
        if (hit(wb_adr_i, OFS_CMP_A)) rd_nxt[15:0] = compare_value_a_src_w;
        if (hit(wb_adr_i, OFS_CMP_B)) rd_nxt[15:0] = compare_value_b_src_w;
        if (hit(wb_adr_i, OFS_CMPCTL)) rd_nxt[15:0] = cmpctl_r;
        if (hit(wb_adr_i, OFS_STAT)) begin
            rd_nxt[ST_OUT_A] = pwm_output_a;
            rd_nxt[ST_OUT_B] = pwm_output_b;
            rd_nxt[ST_UP] = tb_count_up;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (ce && req_w) begin
            wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_nxt;
        end
    end

    // =====================================================================
    // event detection; events only count on a counter step so a held
    // counter value cannot toggle the output more than once
    assign step_w = ce && tb_step;
    assign at_zero_w = time_base_counter == '0;
    assign at_prd_w = time_base_counter == time_base_period;
    assign ca_hit_w = time_base_counter == compare_value_a_act; // [RULE11]
    assign cb_hit_w = time_base_counter == compare_value_b_act;

    always_comb begin
        up_w = tb_count_up;
        if (tb_updown && at_prd_w) up_w = 1'b0; // [RULE8]
        if (tb_updown && at_zero_w) up_w = 1'b1; // [RULE9]
    end

    assign act_a_w = tb_step ? sel_act(ctl_a_r, cb_hit_w, ca_hit_w, at_prd_w, at_zero_w, up_w)
                             : PWMAQ_NOP;
    assign act_b_w = tb_step ? sel_act(ctl_b_r, cb_hit_w, ca_hit_w, at_prd_w, at_zero_w, up_w)
                             : PWMAQ_NOP;

    // =====================================================================
    // qualified outputs
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pwm_output_a <= 1'b0; // [RULE12]
        end else if (ce) begin
            pwm_output_a <= apply_act(act_a_w, pwm_output_a);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pwm_output_b <= 1'b0;
        end else if (ce) begin
            pwm_output_b <= apply_act(act_b_w, pwm_output_b); // [RULE10]
        end
    end

    // =====================================================================
    // assertions
    default clocking cb_clk @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_cb_ev(logic dir);
        step_w && cb_hit_w && up_w == dir;
    endsequence
    sequence s_ca_only(logic dir);
        step_w && ca_hit_w && !cb_hit_w && up_w == dir;
    endsequence
    sequence s_tb_only;
        step_w && !ca_hit_w && !cb_hit_w;
    endsequence

    property p_cbd;
        s_cb_ev(1'b0) ##0 ctl_a_r[11:10] == 2'b10 |=> pwm_output_a;
    endproperty
    a_cbd: assert property (p_cbd) else $error("cmp b down set missed"); // [RULE1]

    property p_cbu;
        s_cb_ev(1'b1) ##0 ctl_a_r[9:8] == 2'b01 |=> !pwm_output_a;
    endproperty
    a_cbu: assert property (p_cbu) else $error("cmp b up clear missed"); // [RULE2]

    property p_cad;
        s_ca_only(1'b0) ##0 ctl_a_r[7:6] == 2'b11 |=> pwm_output_a != $past(pwm_output_a);
    endproperty
    a_cad: assert property (p_cad) else $error("cmp a down toggle missed"); // [RULE3]

    property p_cau;
        s_ca_only(1'b1) ##0 ctl_a_r[5:4] == 2'b10 |=> pwm_output_a;
    endproperty
    a_cau: assert property (p_cau) else $error("cmp a up set missed"); // [RULE4]

    property p_prd;
        s_tb_only ##0 at_prd_w && ctl_a_r[3:2] == 2'b01 |=> !pwm_output_a;
    endproperty
    a_prd: assert property (p_prd) else $error("period clear missed"); // [RULE5]

    property p_zro;
        s_tb_only ##0 at_zero_w && !at_prd_w && ctl_a_r[1:0] == 2'b10 |=> pwm_output_a;
    endproperty
    a_zro: assert property (p_zro) else $error("zero set missed"); // [RULE6]

    property p_tgl_b;
        ce && act_b_w == PWMAQ_TGL |=> pwm_output_b != $past(pwm_output_b);
    endproperty
    a_tgl_b: assert property (p_tgl_b) else $error("toggle on b missed"); // [RULE7]

    // judged through the output, so a wrong direction picks the opposite field
    property p_dir_prd;
        step_w && tb_updown && at_prd_w && !at_zero_w && cb_hit_w
            && ctl_a_r[11:10] == 2'b10 && ctl_a_r[9:8] == 2'b01 |=> pwm_output_a;
    endproperty
    a_dir_prd: assert property (p_dir_prd) else $error("direction at period not down"); // [RULE8]

    property p_dir_zro;
        step_w && tb_updown && at_zero_w && ca_hit_w && !cb_hit_w
            && ctl_a_r[5:4] == 2'b10 && ctl_a_r[7:6] == 2'b01 |=> pwm_output_a;
    endproperty
    a_dir_zro: assert property (p_dir_zro) else $error("direction at zero not up"); // [RULE9]

    property p_ctl_b;
        wr_w && ce && hit(wb_adr_i, OFS_CTL_B) && wb_sel_i[1:0] == 2'b11
            |=> ctl_b_r == {4'h0, $past(wb_dat_i[11:0])};
    endproperty
    a_ctl_b: assert property (p_ctl_b) else $error("ctl b write wrong"); // [RULE10]

    property p_load_a;
        step_w && at_zero_w && !cmpctl_r[CC_IMMA] && cmpctl_r[1:0] == 2'b00
            |=> compare_value_a_act == $past(compare_value_a_shd);
    endproperty
    a_load_a: assert property (p_load_a) else $error("cmp a shadow load missed"); // [RULE11]

    property p_hold;
        ce && act_a_w == PWMAQ_NOP |=> $stable(pwm_output_a);
    endproperty
    a_hold: assert property (p_hold) else $error("output a moved without action"); // [RULE12]

    property p_prio;
        s_cb_ev(1'b1) ##0 ctl_a_r[9:8] == 2'b10 && ca_hit_w && ctl_a_r[5:4] == 2'b01
            |=> pwm_output_a;
    endproperty
    a_prio: assert property (p_prio) else $error("priority cmp b over a lost"); // [RULE13]
endmodule : pwmaq_top

// [test/pwmaq_sink.sv]
// pwmaq_sink: downstream stand-in that counts rising edges of both qualified outputs
`timescale 1ns/1ps
module pwmaq_sink (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // qualified levels
    input wire logic in_a,
    input wire logic in_b,
    // edge counts
    output logic [15:0] rise_a,
    output logic [15:0] rise_b
);
    logic last_a_r;
    logic last_b_r;
    // =====================================================================
    // edge counting, one cycle behind the levels as real registered logic would be
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            last_a_r <= 1'b0;
            last_b_r <= 1'b0;
            rise_a <= 16'h0000;
            rise_b <= 16'h0000;
        end else begin
            last_a_r <= in_a;
            last_b_r <= in_b;
            if (in_a && !last_a_r) rise_a <= rise_a + 16'h0001;
            if (in_b && !last_b_r) rise_b <= rise_b + 16'h0001;
        end
    end
endmodule : pwmaq_sink

// [test/tb_pwm_action_qualifier_ctl.sv]
// tb_pwm_action_qualifier_ctl: self-checking bench with a behavioural model of both outputs
`timescale 1ns/1ps
module tb_pwm_action_qualifier_ctl;
    import pwmaq_pkg::*;
    logic mclk = 1'b0;
    logic rst_b, ce, wb_cyc, wb_stb, wb_we, step, cup, updown, out_a, out_b;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic wb_ack;
    logic [15:0] cnt, period_in, rise_a, rise_b;
    logic [15:0] m_ctl_a, m_ctl_b, m_act_a, m_act_b, m_sh_a, m_sh_b, m_cc, period_v;
    logic exp_a, exp_b, ud_v;
    int exp_ra, exp_rb, fails, check_count, ph;
    integer seed;

    always #5 mclk = ~mclk;

    pwmaq_top u_dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .time_base_counter(cnt),
        .time_base_period(period_in), .tb_step(step), .tb_count_up(cup),
        .tb_updown(updown), .pwm_output_a(out_a), .pwm_output_b(out_b));

    pwmaq_sink u_sink (.mclk(mclk), .rst_b(rst_b), .in_a(out_a), .in_b(out_b),
        .rise_a(rise_a), .rise_b(rise_b));

    // =====================================================================
    // reporting
    task conclude;
        if (fails == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_reg

    task chk_pin(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_pin

    // =====================================================================
    // wishbone classic master
    task wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                  output logic [31:0] rd);
        int k;
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_i <= dat;
        wb_sel <= 4'h3;
        for (k = 0; k < 20; k++) begin
            @(posedge mclk);
            if (wb_ack === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        if (k == 20) begin
            fails++;
            conclude();
        end
    endtask : wb_cycle

    // writes also update the model; imm writes reach active, shadow writes wait for a load
    task wr(input logic [7:0] adr, input logic [15:0] val);
        logic [31:0] rd;
        wb_cycle(1'b1, adr, {16'h0000, val}, rd);
        chk_reg(rd, 32'h0000_0000);
        case (adr)
            OFS_CTL_A: m_ctl_a = val & CTL_RW_MASK;
            OFS_CTL_B: m_ctl_b = val & CTL_RW_MASK;
            OFS_CMPCTL: m_cc = val & CMPCTL_MASK;
            OFS_CMP_A: if (m_cc[CC_IMMA]) m_act_a = val; else m_sh_a = val;
            OFS_CMP_B: if (m_cc[CC_IMMB]) m_act_b = val; else m_sh_b = val;
            default: ;
        endcase
    endtask : wr

    task rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cycle(1'b0, adr, 32'h0000_0000, rd);
        chk_reg(rd, exp);
    endtask : rd_chk

    // =====================================================================
    // reference model
    function automatic logic act(input logic [15:0] c, input logic cur, input logic [15:0] n,
                                 input logic u);
        logic [1:0] a, fa, fb;
        a = 2'b00;
        fa = u ? c[5:4] : c[7:6];
        fb = u ? c[9:8] : c[11:10];
        // lowest priority first so that later hits override; 00 never blocks
        if (n == 16'h0000 && c[1:0] != 2'b00) a = c[1:0];
        if (n == period_v && c[3:2] != 2'b00) a = c[3:2];
        if (n == m_act_a && fa != 2'b00) a = fa;
        if (n == m_act_b && fb != 2'b00) a = fb;
        case (a)
            2'b01: return 1'b0;
            2'b10: return 1'b1;
            2'b11: return ~cur;
            default: return cur;
        endcase
    endfunction : act

    function automatic logic ld(input logic [1:0] m, input logic [15:0] n);
        return (m == 2'b00 && n == 16'h0000) || (m == 2'b01 && n == period_v) ||
               (m == 2'b10 && (n == 16'h0000 || n == period_v));
    endfunction : ld

    task model_reset;
        {m_ctl_a, m_ctl_b, m_act_a, m_act_b, m_sh_a, m_sh_b, m_cc} = '0;
        exp_a = 1'b0;
        exp_b = 1'b0;
    endtask : model_reset

    // =====================================================================
    // random time-base traffic, output checked every cycle
    task run_steps(input int nsteps);
        logic [15:0] n;
        logic u, s, e, d, na, nb;
        int i, r;
        for (i = 0; i < nsteps; i++) begin
            @(posedge mclk);
            r = {$random(seed)} % 6;
            n = r == 0 ? 16'h0000 : r == 1 ? period_v : r == 2 ? m_act_a :
                r == 3 ? m_act_b : 16'($random(seed));
            u = 1'($random(seed));
            s = ({$random(seed)} % 4) != 0;
            e = ({$random(seed)} % 5) != 0;
            cnt <= n;
            cup <= u;
            step <= s;
            ce <= e;
            #1;
            chk_pin(out_a, exp_a);
            chk_pin(out_b, exp_b);
            if (s && e) begin
                d = ud_v ? (n == 16'h0000 ? 1'b1 : n == period_v ? 1'b0 : u) : u;
                na = act(m_ctl_a, exp_a, n, d);
                nb = act(m_ctl_b, exp_b, n, d);
                if (na && !exp_a) exp_ra++;
                if (nb && !exp_b) exp_rb++;
                exp_a = na;
                exp_b = nb;
                if (!m_cc[CC_IMMA] && ld(m_cc[1:0], n)) m_act_a = m_sh_a;
                if (!m_cc[CC_IMMB] && ld(m_cc[3:2], n)) m_act_b = m_sh_b;
            end
        end
        @(posedge mclk);
        step <= 1'b0;
        ce <= 1'b1;
        #1;
        chk_pin(out_a, exp_a);
        chk_pin(out_b, exp_b);
    endtask : run_steps

    // =====================================================================
    // main sequence
    initial begin
        seed = 79457;
        {fails, check_count, exp_ra, exp_rb} = '0;
        {rst_b, wb_cyc, wb_stb, wb_we, step, cup, updown, ud_v} = '0;
        ce = 1'b1;
        wb_adr = 8'h00;
        wb_sel = 4'h0;
        wb_dat_i = 32'h0000_0000;
        cnt = 16'h0000;
        period_in = 16'hffff;
        period_v = 16'hffff;
        model_reset();
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        chk_pin(out_a, 1'b0);
        chk_pin(out_b, 1'b0);
        rd_chk(OFS_CTL_A, 32'h0000_0000);
        rd_chk(OFS_CTL_B, 32'h0000_0000);
        rd_chk(OFS_STAT, 32'h0000_0000);
        for (ph = 0; ph < 40; ph++) begin
            period_v = 16'($random(seed));
            ud_v = 1'($random(seed));
            @(posedge mclk);
            period_in <= period_v;
            updown <= ud_v;
            wr(OFS_CMPCTL, 16'($random(seed)));
            wr(OFS_CMP_A, ({$random(seed)} % 3 == 0) ? 16'h0000 : 16'($random(seed)));
            wr(OFS_CMP_B, ({$random(seed)} % 3 == 0) ? period_v : 16'($random(seed)));
            wr(OFS_CTL_A, 16'($random(seed)));
            wr(OFS_CTL_B, 16'($random(seed)));
            wr(8'h18, 16'hffff);
            rd_chk(OFS_CTL_A, {16'h0000, m_ctl_a});
            rd_chk(OFS_CTL_B, {16'h0000, m_ctl_b});
            rd_chk(8'h18, 32'h0000_0000);
            rd_chk(OFS_CMPCTL, {16'h0000, m_cc});
            rd_chk(OFS_CMP_A, {16'h0000, (m_cc[CC_IMMA] ? m_act_a : m_sh_a)});
            rd_chk(OFS_CMP_B, {16'h0000, (m_cc[CC_IMMB] ? m_act_b : m_sh_b)});
            run_steps(60);
            rd_chk(OFS_STAT, {29'h0, cup, exp_b, exp_a});
        end
        // reset in mid-run must drop both outputs and clear the action fields
        repeat (2) @(posedge mclk);
        #1;
        chk_reg({16'h0000, rise_a}, 32'(exp_ra));
        chk_reg({16'h0000, rise_b}, 32'(exp_rb));
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        model_reset();
        #1;
        chk_pin(out_a, 1'b0);
        chk_pin(out_b, 1'b0);
        rd_chk(OFS_CTL_A, 32'h0000_0000);
        rd_chk(OFS_CTL_B, 32'h0000_0000);
        conclude();
    end
endmodule : tb_pwm_action_qualifier_ctl
